// ### hdl/sms_spi_unit.sv
// Master/slave SPI byte shifter with flags and pin direction control
// Function
// R01 - Master data write starts SCK and shifts eight bits each way.
// R02 - Master stops SCK after one byte and sets the done flag.
// R03 - Done flag with interrupt enable raises the interrupt request.
// R04 - Master never drives slave select by itself; software owns it.
// R05 - Far master lowers select before clocking, raises it per packet.
// R06 - MOSI carries master to slave, MISO slave to master, together.
// R07 - After a byte, master accepts a new write and starts again.
// R08 - Slave with select high stays idle, MISO off, SCK ignored.
// R09 - Slave data written with select high waits for select low.
// R10 - Slave sets the done flag once a full byte has shifted.
// R11 - Last full received byte is kept readable in a buffer.
// R12 - Transmit holds one byte; no new byte until shifting ends.
// R13 - Receive buffer is overwritten if not read before next byte.
// R14 - Far master keeps SCK at or below a quarter of ref_clk.
// R15 - Master forces MISO input; slave forces MOSI, SCK, select input.
// R16 - Bit order selects LSB first or MSB first.
// R17 - Slave select high resets slave bit logic at once.
// R18 - Master with select input seen low drops to slave, sets flag.
// R19 - Polarity sets SCK idle level; phase picks the sampling edge.
// R20 - Rate bits and double speed pick the master SCK divider.
// R21 - Data write during a transfer is dropped and flags collision.
// R22 - Flags clear on status read then data access, or on service.
`default_nettype none
module sms_spi_unit
    import sms_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ctrl_wr,
    input wire sms_ctrl_s ctrl_in,
    output sms_ctrl_s serial_control_register,
    input wire logic data_wr,
    input wire logic [FRAME_BITS-1:0] data_in,
    input wire logic data_rd,
    input wire logic status_rd,
    input wire logic irq_ack,
    input wire sms_dir_s dir,
    input wire logic ss_gpio,
    output logic [FRAME_BITS-1:0] rx_data,
    output logic transfer_done_flag,
    output logic write_collision_flag,
    output logic irq,
    output logic busy,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic ss_n_in,
    output logic ss_out,
    output logic ss_oe
);
    sms_state_e state;
    logic [3:0] edge_cnt;
    logic sck_prev;
    logic sampled;
    logic done_pulse;
    logic status_armed;
    logic tick;
    logic [FRAME_BITS-1:0] word;
    logic out_bit;
    logic en;
    logic is_master;
    logic slave_live;
    logic edge_ev;
    logic sample_ev;
    logic last_ev;
    logic shift_en;
    logic live_in;
    logic accept;
    logic start;
    logic collide;
    logic abort;
    logic clear_ev;
    logic done_set;
    logic [FRAME_BITS-1:0] landed;

    assign en = serial_control_register.serial_port_enable;
    assign is_master = serial_control_register.master_select_bit;
    assign slave_live = en && !is_master && !ss_n_in;

    sms_rate_gen u_rate (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .run(state == SMS_RUN),
        .half_m1(sms_half(serial_control_register)), // R20
        .tick(tick)
    );

    // One SCK edge, from own divider or the far master's clock
    assign edge_ev = is_master ? (state == SMS_RUN && tick) // R01
                               : (slave_live && sck_in != sck_prev); // R08
    assign sample_ev = edge_ev
        && (edge_cnt[0] == serial_control_register.clock_phase); // R19
    assign last_ev = edge_ev && edge_cnt == LAST_EDGE;
    assign live_in = is_master ? miso_in : mosi_in; // R06
    // Phase one takes its last bit a cycle late, off the sampling edge,
    // so the data pins never move at the instant the far side samples
    assign shift_en = (edge_ev && !sample_ev && edge_cnt != FIRST_EDGE)
        || (done_pulse && serial_control_register.clock_phase); // R06
    // Byte as it stands once its last shift is done
    assign landed = !serial_control_register.clock_phase ? word
        : serial_control_register.bit_order_select
            ? {sampled, word[FRAME_BITS-1:1]}
            : {word[FRAME_BITS-2:0], sampled};

    assign busy = state == SMS_RUN || edge_cnt != FIRST_EDGE || done_pulse;
    assign accept = data_wr && !busy; // R12
    assign collide = data_wr && busy; // R21
    // A select-low abort outranks a start in the same cycle
    assign start = accept && en && is_master && !abort; // R07
    assign abort = en && is_master && !dir.ss && !ss_n_in; // R18
    assign done_set = done_pulse || abort; // R10
    assign clear_ev = (status_armed && (data_rd || data_wr)) || irq_ack;

    sms_shifter #(
        .WIDTH(FRAME_BITS)
    ) u_shift (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .load(accept), // R09
        .load_val(data_in),
        .shift_en(shift_en),
        .bit_in(sampled),
        .lsb_first(serial_control_register.bit_order_select), // R16
        .word(word),
        .out_bit(out_bit)
    );

    // Hardware clearing of master select outranks a software write
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            serial_control_register <= CTRL_RESET;
        else if (abort)
            serial_control_register.master_select_bit <= 1'b0; // R18
        else if (ctrl_wr)
            serial_control_register <= ctrl_in;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            state <= SMS_IDLE;
        else
        begin
            case (state)
                SMS_IDLE:
                    if (start)
                        state <= SMS_RUN; // R01
                SMS_RUN:
                    if (last_ev || abort || !en)
                        state <= SMS_IDLE; // R02
                default:
                    state <= SMS_IDLE;
            endcase
        end
    end

    // Select high in slave mode pins the counter at zero
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            edge_cnt <= FIRST_EDGE;
        else if (abort || start || (!is_master && !slave_live))
            edge_cnt <= FIRST_EDGE; // R17
        else if (edge_ev)
            edge_cnt <= edge_cnt + 4'h1;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            sck_prev <= 1'b0;
        else
            sck_prev <= sck_in;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            sampled <= 1'b0;
        else if (sample_ev)
            sampled <= live_in;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            sck_out <= 1'b0;
        else if (state != SMS_RUN)
            sck_out <= serial_control_register.clock_polarity; // R19
        else if (tick)
            sck_out <= !sck_out;
    end

    // Byte lands one cycle after its last edge; busy covers the gap
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            done_pulse <= 1'b0;
        else
            done_pulse <= last_ev && !abort;
    end

    // No read guard: an unread byte is simply overwritten
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            rx_data <= RX_RESET;
        else if (done_pulse)
            rx_data <= landed; // R11 R13
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            status_armed <= 1'b0;
        else if (clear_ev)
            status_armed <= 1'b0;
        else if (status_rd && (transfer_done_flag || write_collision_flag))
            status_armed <= 1'b1;
    end

    // A new event in the clearing cycle keeps its flag
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            transfer_done_flag <= 1'b0;
        else if (done_set)
            transfer_done_flag <= 1'b1; // R02 R10 R18
        else if (clear_ev)
            transfer_done_flag <= 1'b0; // R22
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            write_collision_flag <= 1'b0;
        else if (collide)
            write_collision_flag <= 1'b1; // R21
        else if (clear_ev)
            write_collision_flag <= 1'b0; // R22
    end

    assign irq = transfer_done_flag
        && serial_control_register.transfer_irq_enable; // R03

    // Pin directions: forced inputs per role, for deselected slave MISO and, bar select, when disabled; else the user direction
    always_comb
    begin
        mosi_out = out_bit; // R06
        miso_out = out_bit;
        ss_out = ss_gpio; // R04
        ss_oe = dir.ss;
        mosi_oe = 1'b0;
        sck_oe = 1'b0;
        miso_oe = 1'b0;
        if (en && is_master)
        begin
            mosi_oe = dir.mosi; // R15
            sck_oe = dir.sck;
        end
        else if (en)
        begin
            ss_oe = 1'b0; // R15
            miso_oe = dir.miso && !ss_n_in; // R08
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    done_irq_a: assert property ( // R03
        $rose(transfer_done_flag)
            && serial_control_register.transfer_irq_enable |-> irq)
        else $error("done flag with enable gave no interrupt");

    master_stop_a: assert property ( // R02
        state == SMS_RUN && last_ev && !abort
            |=> state == SMS_IDLE ##1 transfer_done_flag && !tick)
        else $error("master did not stop and flag after one byte");

    master_start_a: assert property ( // R01
        state == SMS_IDLE && start |=> state == SMS_RUN && edge_cnt == 4'h0)
        else $error("data write did not start master transfer");

    sck_idle_a: assert property ( // R19
        state == SMS_IDLE ##1 state == SMS_IDLE
            |-> sck_out == $past(serial_control_register.clock_polarity))
        else $error("idle SCK level differs from polarity");

    miso_tri_a: assert property ( // R08
        en && !is_master && ss_n_in |-> !miso_oe && !edge_ev)
        else $error("slave active while select high");

    master_miso_a: assert property ( // R15
        en && is_master |-> !miso_oe)
        else $error("master drives MISO");

    collide_flag_a: assert property ( // R21
        data_wr && busy
            |=> write_collision_flag && ($past(shift_en) || $stable(word)))
        else $error("write during transfer not refused");

    ss_abort_a: assert property ( // R18
        abort |=> !is_master && transfer_done_flag && state == SMS_IDLE)
        else $error("select low in master mode not handled");

    slave_reset_a: assert property ( // R17
        !is_master && ss_n_in |=> edge_cnt == 4'h0)
        else $error("slave counter not reset by select high");

    rx_keep_a: assert property ( // R11
        done_pulse |=> rx_data == word)
        else $error("received byte not kept");
endmodule // sms_spi_unit
`default_nettype wire

// ### hdl/sms_pkg.sv
// Shared constants, states and carriers of the SPI shifter
`default_nettype none
package sms_pkg;
    localparam int FRAME_BITS = 8;
    localparam logic [3:0] LAST_EDGE = 4'hF;
    localparam logic [3:0] FIRST_EDGE = 4'h0;
    // Half SCK period minus one, in ref_clk cycles, per rate code
    localparam logic [5:0] HALF_DIV4 = 6'h01;
    localparam logic [5:0] HALF_DIV16 = 6'h07;
    localparam logic [5:0] HALF_DIV64 = 6'h1F;
    localparam logic [5:0] HALF_DIV128 = 6'h3F;
    localparam logic [5:0] HALF_DIV2 = 6'h00;
    localparam logic [5:0] HALF_DIV8 = 6'h03;
    localparam logic [5:0] HALF_DIV32 = 6'h0F;
    localparam logic [7:0] RX_RESET = 8'h00;

    typedef enum logic [0:0] {
        SMS_IDLE = 1'b0,
        SMS_RUN = 1'b1
    } sms_state_e;

    typedef struct packed {
        logic transfer_irq_enable;
        logic serial_port_enable;
        logic bit_order_select;
        logic master_select_bit;
        logic clock_polarity;
        logic clock_phase;
        logic rate_select_hi;
        logic rate_select_lo;
        logic double_speed_bit;
    } sms_ctrl_s;

    localparam sms_ctrl_s CTRL_RESET = '0;

    typedef struct packed {
        logic mosi;
        logic miso;
        logic sck;
        logic ss;
    } sms_dir_s;

    function automatic logic [5:0] sms_half(input sms_ctrl_s c);
        logic [2:0] code;
        code = {c.double_speed_bit, c.rate_select_hi, c.rate_select_lo};
        case (code)
            3'h0: sms_half = HALF_DIV4;
            3'h1: sms_half = HALF_DIV16;
            3'h2: sms_half = HALF_DIV64;
            3'h3: sms_half = HALF_DIV128;
            3'h4: sms_half = HALF_DIV2;
            3'h5: sms_half = HALF_DIV8;
            3'h6: sms_half = HALF_DIV32;
            default: sms_half = HALF_DIV64;
        endcase
    endfunction
endpackage
`default_nettype wire

// ### hdl/sms_rate_gen.sv
// Master SCK half-period tick generator
`default_nettype none
module sms_rate_gen
    import sms_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic [5:0] half_m1,
    output logic tick
);
    logic [5:0] count;

    assign tick = run && (count == half_m1);

    // Restart from zero at every start so the first edge is a full half
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            count <= 6'h00;
        else if (!run || tick)
            count <= 6'h00;
        else
            count <= count + 6'h01;
    end
endmodule // sms_rate_gen
`default_nettype wire

// ### hdl/sms_shifter.sv
// Shift register with selectable bit order
`default_nettype none
module sms_shifter
    import sms_pkg::*;
#(
    parameter int WIDTH = FRAME_BITS
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    input wire logic shift_en,
    input wire logic bit_in,
    input wire logic lsb_first,
    output logic [WIDTH-1:0] word,
    output logic out_bit
);
    if (WIDTH < 2)
    begin : g_bad_width
        $error("sms_shifter needs WIDTH of at least 2");
    end

    assign out_bit = lsb_first ? word[0] : word[WIDTH-1];

    // Out bit leaves one end while the taken bit enters the other
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            word <= '0;
        else if (load)
            word <= load_val;
        else if (shift_en && lsb_first)
            word <= {bit_in, word[WIDTH-1:1]};
        else if (shift_en)
            word <= {word[WIDTH-2:0], bit_in};
    end
endmodule // sms_shifter
`default_nettype wire

// ### verif/sms_far_model.sv
// Far-side SPI slave that answers the unit while it is master
`default_nettype none
module sms_far_model
(
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic lsb,
    input wire logic [7:0] tx,
    output logic miso,
    output logic [7:0] rx
);
    timeunit 1ns;
    timeprecision 1ps;
    int k = 0;
    initial miso = 1'b0;
    initial rx = 8'h00;
    function automatic logic pick(input int i);
        return lsb ? tx[i] : tx[7 - i];
    endfunction
    // A new packet restarts the count; first bit is ready before any edge
    always @(negedge ss_n)
    begin
        k = 0;
        miso <= pick(0);
    end
    // Released line shows the inverse of its last value, never a held bit
    always @(posedge ss_n)
        miso <= ~miso;
    always @(sck)
    begin
        if (!ss_n && (sck ^ cpol ^ cpha))
        begin
            rx <= lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
            k = k + 1;
        end
        else if (!ss_n && k < 8)
            miso <= pick(k);
    end
endmodule // sms_far_model
`default_nettype wire

// ### verif/test_sms_spi_unit.sv
// Self-checking bench of the SPI shifter unit
`default_nettype none
module test_sms_spi_unit
    import sms_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic ctrl_wr = 1'b0, data_wr = 1'b0, data_rd = 1'b0;
    logic status_rd = 1'b0, irq_ack = 1'b0, ss_gpio = 1'b1;
    logic b_sck = 1'b0, b_mosi = 1'b0, b_ss_n = 1'b1;
    logic [7:0] data_in = 8'h00, far_tx = 8'h00;
    sms_ctrl_s ctrl_in = CTRL_RESET, c = CTRL_RESET;
    sms_dir_s dir = 4'hB;
    sms_ctrl_s serial_control_register;
    logic [7:0] rx_data, far_rx;
    logic transfer_done_flag, write_collision_flag, irq, busy;
    logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
    logic ss_out, ss_oe, far_miso;
    int miscompares = 0, n_checks = 0;

    always #2.5 ref_clk = ~ref_clk;

    sms_spi_unit uut (
        .ref_clk, .resetn, .ctrl_wr, .ctrl_in, .serial_control_register,
        .data_wr, .data_in, .data_rd, .status_rd, .irq_ack, .dir, .ss_gpio,
        .rx_data, .transfer_done_flag, .write_collision_flag, .irq, .busy,
        .sck_in(b_sck), .sck_out, .sck_oe, .mosi_in(b_mosi), .mosi_out,
        .mosi_oe, .miso_in(far_miso), .miso_out, .miso_oe,
        .ss_n_in(b_ss_n), .ss_out, .ss_oe
    );
    sms_far_model far (
        .sck(sck_out), .ss_n(ss_out), .mosi(mosi_out),
        .cpol(c.clock_polarity), .cpha(c.clock_phase),
        .lsb(c.bit_order_select), .tx(far_tx), .miso(far_miso), .rx(far_rx)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        if (miscompares == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge ref_clk);
    endtask

    function automatic int exp_div(input logic [2:0] r);
        int t[8] = '{4, 16, 64, 128, 2, 8, 32, 64};
        return t[r];
    endfunction

    task automatic cfg(input sms_ctrl_s v);
        ctrl_in = v;
        ctrl_wr = 1'b1;
        tick(1);
        ctrl_wr = 1'b0;
        c = v;
        b_sck = v.clock_polarity;
        tick(4);
    endtask

    // Status read arms the flag clear, the data write completes it
    task automatic load(input logic [7:0] d);
        status_rd = 1'b1;
        tick(1);
        status_rd = 1'b0;
        data_in = d;
        data_wr = 1'b1;
        tick(1);
        data_wr = 1'b0;
    endtask

    task automatic mxfer(input logic [7:0] d, input logic coll);
        int n;
        far_tx = 8'($urandom);
        ss_gpio = 1'b0;
        tick(1);
        load(d);
        data_in = ~d;
        n = 1;
        while (transfer_done_flag !== 1'b1 && n < 2000)
        begin
            if (coll && (n == 4 || n == 5))
                data_wr = n == 4;
            tick(1);
            n++;
        end
        chk(16'(n), 16'(8 * exp_div({c.double_speed_bit, c.rate_select_hi,
            c.rate_select_lo}) + 2));
        chk(busy, 1'b0);
        chk(write_collision_flag, coll);
        chk(irq, c.transfer_irq_enable);
        chk(rx_data, far_tx);
        chk(sck_out, c.clock_polarity);
        chk({miso_oe, mosi_oe, sck_oe, ss_oe, ss_out},
            {1'b0, dir.mosi, dir.sck, dir.ss, 1'b0});
        chk(far_rx, d);
        ss_gpio = 1'b1;
        tick(2);
    endtask

    task automatic sxfer(input logic [7:0] d, input int nb);
        logic [7:0] tx;
        logic [7:0] got;
        tx = 8'($urandom);
        got = 8'h00;
        load(tx);
        // Clock pulses while deselected must be ignored
        repeat (6)
        begin
            b_sck = ~b_sck;
            tick(4);
        end
        chk(miso_oe, 1'b0);
        b_ss_n = 1'b0;
        tick(4);
        chk(miso_oe, dir.miso);
        for (int i = 0; i < nb; i++)
        begin
            b_mosi = c.bit_order_select ? d[i] : d[7 - i];
            if (c.clock_phase)
                b_sck = ~b_sck;
            tick(4);
            got[c.bit_order_select ? i : 7 - i] = miso_out;
            b_sck = ~b_sck;
            tick(4);
            if (!c.clock_phase)
                b_sck = ~b_sck;
        end
        tick(6);
        if (nb == 8)
        begin
            chk(got, tx);
            chk(rx_data, d);
            chk(transfer_done_flag, 1'b1);
        end
        b_ss_n = 1'b1;
        tick(4);
    endtask

    initial
    begin
        sms_ctrl_s v;
        void'($urandom(32'hBE252E51));
        tick(5);
        chk(serial_control_register, CTRL_RESET);
        chk({rx_data, transfer_done_flag, write_collision_flag}, 10'h000);
        resetn = 1'b1;
        tick(1);
        for (int j = 0; j < 12; j++)
        begin
            v = sms_ctrl_s'(9'($urandom));
            v.serial_port_enable = 1'b1;
            v.master_select_bit = 1'b1;
            {v.double_speed_bit, v.rate_select_hi, v.rate_select_lo} = 3'(j);
            {v.clock_polarity, v.clock_phase} = 2'(j >> 1);
            cfg(v);
            mxfer(8'($urandom), j == 3);
        end
        dir = 4'h4;
        for (int j = 0; j < 4; j++)
        begin
            v = sms_ctrl_s'(9'($urandom));
            v.serial_port_enable = 1'b1;
            v.master_select_bit = 1'b0;
            {v.clock_polarity, v.clock_phase} = 2'(j);
            cfg(v);
            sxfer(8'($urandom), 3);
            sxfer(8'($urandom), 8);
            sxfer(8'($urandom), 8);
        end
        dir = 4'hA;
        v.master_select_bit = 1'b1;
        cfg(v);
        irq_ack = 1'b1;
        tick(1);
        irq_ack = 1'b0;
        chk({transfer_done_flag, write_collision_flag}, 2'b00);
        b_ss_n = 1'b0;
        tick(4);
        chk({serial_control_register.master_select_bit, transfer_done_flag,
            sck_oe, mosi_oe}, 4'h4);
        status_rd = 1'b1;
        tick(1);
        status_rd = 1'b0;
        data_rd = 1'b1;
        tick(1);
        data_rd = 1'b0;
        chk(transfer_done_flag, 1'b0);
        b_ss_n = 1'b1;
        tick(2);
        end_of_test();
    end

    // The longest run is a few thousand cycles; this leaves ample margin
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        end_of_test();
    end
endmodule // test_sms_spi_unit
`default_nettype wire
